//--- sqlb_regs.svh
// What this block does
// - Outgoing stores wait in an eight-entry first-in first-out queue of one 16-byte quadword each before they go to the bus.
// - Narrow stores to the accelerated uncached space that follow on sequentially are merged into the last queue entry.
// - There is exactly one load line buffer entry, holding eight quadwords of accelerated uncached load data.
// - An accelerated uncached load that misses the line buffer fetches and keeps a run of 128 sequential bytes.
// - A later accelerated uncached load that hits the line buffer is served from it with no bus transaction.
// - The bus path carries 128-bit data on lines separate from a 32-bit address, and addresses may be pipelined.
// - The line buffer lookup starts in the execution stage beside the data cache read and completes in the data-fetch stage.
//
// Purpose: constants of the store queue and load line buffer
// Assumes: one core clock, 32-bit byte addresses
// Notes: definitions only
`ifndef SQLB_REGS_SVH
`define SQLB_REGS_SVH

`define SQLB_ADDR_W 32
`define SQLB_DATA_W 128
`define SQLB_BE_W 16
`define SQLB_WQ_DEPTH 8
`define SQLB_WQ_PTR_W 3
`define SQLB_WQ_CNT_W 4
`define SQLB_LINE_QWS 8
`define SQLB_LINE_BYTES 128
`define SQLB_QW_LSB 4
`define SQLB_LINE_LSB 7
`define SQLB_BEAT_W 3

`endif

//--- sqlb_pkg.sv
// Purpose: types shared by the store queue and load line buffer
// Assumes: constants come from sqlb_regs.svh
// Notes: none
`include "sqlb_regs.svh"

package sqlb_pkg;

	typedef struct packed {
		logic [`SQLB_ADDR_W-1:0] addr;
		logic [`SQLB_DATA_W-1:0] data;
		logic [`SQLB_BE_W-1:0] be;
		logic accel;
	} sqlb_store_t;

	typedef struct packed {
		logic [`SQLB_ADDR_W-1:0] addr;
		logic [`SQLB_DATA_W-1:0] data;
		logic [`SQLB_BE_W-1:0] be;
	} sqlb_bus_wr_t;

	typedef enum logic [1:0] {
		SQLB_FILL_IDLE = 2'b00,
		SQLB_FILL_REQ = 2'b01,
		SQLB_FILL_DATA = 2'b10
	} sqlb_fill_state_t;

endpackage

//--- sqlb_top.sv
// Purpose: store queue with gathering, and single-line accelerated load buffer
// Assumes: loads presented here are accelerated uncached loads only
// Notes: fill starts only once the store queue is empty, keeping bus order
`timescale 1ns/1ps
`include "sqlb_regs.svh"

module sqlb_top (
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic st_valid,
	output logic st_ready,
	input wire sqlb_pkg::sqlb_store_t st_req,
	output logic wq_valid,
	input wire logic wq_ready,
	output sqlb_pkg::sqlb_bus_wr_t wq_out,
	input wire logic ld_valid,
	output logic ld_ready,
	input wire logic [`SQLB_ADDR_W-1:0] ld_addr,
	output logic ld_done_r,
	output logic ld_hit_r,
	output logic ld_miss_r,
	output logic [`SQLB_DATA_W-1:0] ld_data_r,
	input wire logic llb_flush,
	output logic fill_req,
	input wire logic fill_ack,
	output logic [`SQLB_ADDR_W-1:0] fill_addr_r,
	input wire logic fill_valid,
	input wire logic [`SQLB_DATA_W-1:0] fill_data,
	output logic fill_busy
);

	localparam int LTAG_W = `SQLB_ADDR_W - `SQLB_LINE_LSB;

	function automatic logic [3:0] sqlb_first_byte(input logic [15:0] be);
		logic [3:0] idx;
		idx = 4'hF;
		for (int i = 15; i >= 0; i--) begin
			if (be[i]) begin
				idx = 4'(i);
			end
		end
		return idx;
	endfunction

	function automatic logic [3:0] sqlb_last_byte(input logic [15:0] be);
		logic [3:0] idx;
		idx = 4'h0;
		for (int i = 0; i < 16; i++) begin
			if (be[i]) begin
				idx = 4'(i);
			end
		end
		return idx;
	endfunction

	// Store queue state
	sqlb_pkg::sqlb_store_t wq_mem_r [`SQLB_WQ_DEPTH];
	sqlb_pkg::sqlb_store_t wq_mem_nxt [`SQLB_WQ_DEPTH];
	logic [`SQLB_WQ_PTR_W-1:0] wq_head_r, wq_head_nxt;
	logic [`SQLB_WQ_PTR_W-1:0] wq_tail_r, wq_tail_nxt;
	logic [`SQLB_WQ_CNT_W-1:0] wq_cnt_r, wq_cnt_nxt;
	logic [`SQLB_WQ_PTR_W-1:0] wq_last;
	sqlb_pkg::sqlb_store_t last_ent;
	logic wq_pop, st_take, merge_ok, wq_full;

	// Load line buffer state
	logic [`SQLB_DATA_W-1:0] llb_mem_r [`SQLB_LINE_QWS];
	logic [`SQLB_DATA_W-1:0] llb_mem_nxt [`SQLB_LINE_QWS];
	logic [LTAG_W-1:0] llb_tag_r, llb_tag_nxt;
	logic llb_valid_r, llb_valid_nxt;
	sqlb_pkg::sqlb_fill_state_t fill_st_r, fill_st_nxt;
	logic [`SQLB_BEAT_W-1:0] beat_r, beat_nxt;
	logic [`SQLB_ADDR_W-1:0] fill_addr_nxt;
	logic ld_done_nxt, ld_hit_nxt, ld_miss_nxt;
	logic [`SQLB_DATA_W-1:0] ld_data_nxt;
	logic a_hit, st_hits_line;
	logic [LTAG_W-1:0] ld_addr_d_r, ld_addr_d_nxt;

	assign wq_last = wq_tail_r - 3'h1;
	assign last_ent = wq_mem_r[wq_last];
	assign wq_full = (wq_cnt_r == 4'(`SQLB_WQ_DEPTH));
	assign wq_pop = wq_valid && wq_ready;
	assign wq_valid = (wq_cnt_r != 4'h0);
	assign wq_out.addr = wq_mem_r[wq_head_r].addr;
	assign wq_out.data = wq_mem_r[wq_head_r].data;
	assign wq_out.be = wq_mem_r[wq_head_r].be;

	// Gather only into the newest entry, never one leaving this cycle
	always_comb begin
		merge_ok = st_req.accel && last_ent.accel && wq_valid &&
			(st_req.addr[`SQLB_ADDR_W-1:`SQLB_QW_LSB] ==
			last_ent.addr[`SQLB_ADDR_W-1:`SQLB_QW_LSB]) &&
			(st_req.be != 16'h0000) && !last_ent.be[15] &&
			((st_req.be & last_ent.be) == 16'h0000) &&
			(sqlb_first_byte(st_req.be) ==
			sqlb_last_byte(last_ent.be) + 4'h1) &&
			!(wq_pop && wq_cnt_r == 4'h1);
	end

	assign st_ready = merge_ok || !wq_full;
	assign st_take = st_valid && st_ready;

	always_comb begin
		wq_mem_nxt = wq_mem_r;
		wq_head_nxt = wq_head_r;
		wq_tail_nxt = wq_tail_r;
		wq_cnt_nxt = wq_cnt_r;
		if (st_take && merge_ok) begin
			for (int b = 0; b < `SQLB_BE_W; b++) begin
				if (st_req.be[b]) begin
					wq_mem_nxt[wq_last].data[b*8 +: 8] =
						st_req.data[b*8 +: 8];
				end
			end
			wq_mem_nxt[wq_last].be = last_ent.be | st_req.be;
		end else if (st_take) begin
			wq_mem_nxt[wq_tail_r] = st_req;
			wq_tail_nxt = wq_tail_r + 3'h1;
		end
		if (wq_pop) begin
			wq_head_nxt = wq_head_r + 3'h1;
		end
		case ({st_take && !merge_ok, wq_pop})
			2'b10: wq_cnt_nxt = wq_cnt_r + 4'h1;
			2'b01: wq_cnt_nxt = wq_cnt_r - 4'h1;
			default: wq_cnt_nxt = wq_cnt_r;
		endcase
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			for (int i = 0; i < `SQLB_WQ_DEPTH; i++) begin
				wq_mem_r[i] <= '0;
			end
			wq_head_r <= 3'h0;
			wq_tail_r <= 3'h0;
			wq_cnt_r <= 4'h0;
		end else begin
			wq_mem_r <= wq_mem_nxt;
			wq_head_r <= wq_head_nxt;
			wq_tail_r <= wq_tail_nxt;
			wq_cnt_r <= wq_cnt_nxt;
		end
	end

	// Line buffer: tag compare in the execution stage, result one cycle on
	assign fill_busy = (fill_st_r != sqlb_pkg::SQLB_FILL_IDLE);
	assign ld_ready = !fill_busy && !ld_miss_r;
	assign a_hit = llb_valid_r &&
		(ld_addr[`SQLB_ADDR_W-1:`SQLB_LINE_LSB] == llb_tag_r);
	assign st_hits_line = st_take && st_req.accel &&
		(st_req.addr[`SQLB_ADDR_W-1:`SQLB_LINE_LSB] == llb_tag_r);
	assign fill_req = (fill_st_r == sqlb_pkg::SQLB_FILL_REQ) &&
		(wq_cnt_r == 4'h0);

	always_comb begin
		llb_mem_nxt = llb_mem_r;
		llb_tag_nxt = llb_tag_r;
		llb_valid_nxt = llb_valid_r;
		fill_st_nxt = fill_st_r;
		beat_nxt = beat_r;
		fill_addr_nxt = fill_addr_r;
		ld_done_nxt = 1'b0;
		ld_hit_nxt = 1'b0;
		ld_miss_nxt = 1'b0;
		ld_data_nxt = ld_data_r;
		if (ld_valid && ld_ready) begin
			ld_done_nxt = 1'b1;
			ld_hit_nxt = a_hit;
			ld_miss_nxt = !a_hit;
			ld_data_nxt = a_hit ?
				llb_mem_r[ld_addr[`SQLB_LINE_LSB-1:`SQLB_QW_LSB]] :
				'0;
		end
		case (fill_st_r)
			sqlb_pkg::SQLB_FILL_IDLE: begin
				if (ld_miss_r) begin
					fill_st_nxt = sqlb_pkg::SQLB_FILL_REQ;
					llb_valid_nxt = 1'b0;
				end
			end
			sqlb_pkg::SQLB_FILL_REQ: begin
				if (fill_req && fill_ack) begin
					fill_st_nxt = sqlb_pkg::SQLB_FILL_DATA;
					beat_nxt = 3'h0;
				end
			end
			sqlb_pkg::SQLB_FILL_DATA: begin
				if (fill_valid) begin
					llb_mem_nxt[beat_r] = fill_data;
					beat_nxt = beat_r + 3'h1;
					if (beat_r == 3'(`SQLB_LINE_QWS - 1)) begin
						fill_st_nxt = sqlb_pkg::SQLB_FILL_IDLE;
						llb_tag_nxt =
							fill_addr_r[`SQLB_ADDR_W-1:`SQLB_LINE_LSB];
						llb_valid_nxt = 1'b1;
					end
				end
			end
			default: fill_st_nxt = sqlb_pkg::SQLB_FILL_IDLE;
		endcase
		if (ld_miss_r && fill_st_r == sqlb_pkg::SQLB_FILL_IDLE) begin
			fill_addr_nxt = {ld_addr_d_r, `SQLB_LINE_LSB'(0)};
		end
		// An accelerated store into the held line or a flush drops the line
		if (st_hits_line || llb_flush) begin
			llb_valid_nxt = 1'b0;
		end
	end

	assign ld_addr_d_nxt = (ld_valid && ld_ready) ?
		ld_addr[`SQLB_ADDR_W-1:`SQLB_LINE_LSB] : ld_addr_d_r;

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			for (int i = 0; i < `SQLB_LINE_QWS; i++) begin
				llb_mem_r[i] <= '0;
			end
			llb_tag_r <= '0;
			llb_valid_r <= 1'b0;
			fill_st_r <= sqlb_pkg::SQLB_FILL_IDLE;
			beat_r <= 3'h0;
			fill_addr_r <= 32'h00000000;
			ld_done_r <= 1'b0;
			ld_hit_r <= 1'b0;
			ld_miss_r <= 1'b0;
			ld_data_r <= '0;
			ld_addr_d_r <= '0;
		end else begin
			llb_mem_r <= llb_mem_nxt;
			llb_tag_r <= llb_tag_nxt;
			llb_valid_r <= llb_valid_nxt;
			fill_st_r <= fill_st_nxt;
			beat_r <= beat_nxt;
			fill_addr_r <= fill_addr_nxt;
			ld_done_r <= ld_done_nxt;
			ld_hit_r <= ld_hit_nxt;
			ld_miss_r <= ld_miss_nxt;
			ld_data_r <= ld_data_nxt;
			ld_addr_d_r <= ld_addr_d_nxt;
		end
	end

endmodule

//--- sqlb_chk_assertions.sv
// Purpose: port assertions for sqlb_top
// Assumes: one clock, reset active high
// Notes: bc_r counts fill beats
`timescale 1ns/1ps
module sqlb_chk (
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic st_valid,
	input wire logic st_ready,
	input wire logic wq_valid,
	input wire logic wq_ready,
	input wire sqlb_pkg::sqlb_bus_wr_t wq_out,
	input wire logic ld_valid,
	input wire logic ld_ready,
	input wire logic ld_done_r,
	input wire logic ld_hit_r,
	input wire logic ld_miss_r,
	input wire logic [31:0] fill_addr_r,
	input wire logic fill_req,
	input wire logic fill_valid,
	input wire logic fill_busy
);
	logic [3:0] bc_r, bc_nxt;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (reset);
	sequence s_miss; ld_miss_r ##1 !wq_valid; endsequence
	sequence s_last; fill_valid && bc_r == 4'h7; endsequence
	always_comb bc_nxt = fill_busy ? bc_r + {3'h0, fill_valid} : 4'h0;
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset)
			bc_r <= 4'h0;
		else
			bc_r <= bc_nxt;
	end
	a_load_answer: assert property (ld_valid && ld_ready |=> ld_done_r)
		else $error("load not answered");
	a_hit_or_miss: assert property (ld_done_r |-> ld_hit_r != ld_miss_r)
		else $error("bad load result");
	a_miss_holds: assert property (ld_miss_r |-> !ld_ready)
		else $error("load taken on miss");
	a_fill_start: assert property (s_miss |-> fill_req && fill_busy)
		else $error("fill not requested");
	a_fill_align: assert property (fill_busy |-> fill_addr_r[6:0] == 7'h0)
		else $error("fill address unaligned");
	a_eight_beats: assert property (s_last |=> !fill_busy)
		else $error("fill not ended at beat 8");
	a_head_stable: assert property (wq_valid && !wq_ready && !st_valid
		|=> wq_valid && $stable(wq_out))
		else $error("queue head moved");
	a_refuse_full: assert property (st_valid && !st_ready |-> wq_valid)
		else $error("store refused when not full");
	a_store_seen: assert property (st_valid && st_ready |=> wq_valid)
		else $error("store not queued");
endmodule
bind sqlb_top sqlb_chk sqlb_chk_i (.*);

//--- sqlb_biu_model.sv
// Purpose: bus side model, takes writes and returns line fills
// Assumes: hold stalls both directions
// Notes: fill quadword k carries its own address
`timescale 1ns/1ps
module sqlb_biu_model (
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic hold,
	input wire logic fill_req,
	input wire logic [31:0] fill_addr_r,
	output logic wq_ready,
	output logic fill_ack,
	output logic fill_valid,
	output logic [127:0] fill_data
);
	logic [3:0] beat_r;
	assign wq_ready = !hold;
	assign fill_ack = fill_req && beat_r == 4'h0 && !hold;
	assign fill_valid = beat_r != 4'h0 && !hold;
	// Idle data is scrambled so stale beats never match
	assign fill_data = fill_valid ?
		{4{fill_addr_r + {beat_r - 4'h1, 4'h0}}} : ~{4{fill_addr_r}};
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset)
			beat_r <= 4'h0;
		else if (fill_ack)
			beat_r <= 4'h1;
		else if (fill_valid)
			beat_r <= beat_r == 4'h8 ? 4'h0 : beat_r + 4'h1;
	end
endmodule

//--- tb_top.sv
// Purpose: self-checking bench for sqlb_top
// Assumes: sqlb_biu_model on the bus side
// Notes: fixed seed
`timescale 1ns/1ps
module tb_top;
	logic sys_clk = 1'b0, reset = 1'b1, st_valid = 1'b0, ld_valid = 1'b0;
	logic llb_flush = 1'b0, hold = 1'b0, rnd = 1'b0, stop = 1'b0;
	sqlb_pkg::sqlb_store_t st_req = '0;
	sqlb_pkg::sqlb_bus_wr_t wq_out, exp_q[$], got_q[$];
	logic [31:0] ld_addr = 32'h0, fill_addr_r, a;
	logic [127:0] ld_data_r, fill_data, d;
	logic st_ready, wq_valid, wq_ready, ld_ready, ld_done_r, ld_hit_r;
	logic ld_miss_r, fill_req, fill_ack, fill_valid, fill_busy;
	int err_count = 0, num_checks = 0, cyc = 0, fills = 0;
	sqlb_top sqlb_top_i (.*);
	sqlb_biu_model sqlb_biu_model_i (.*);
	always #4 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		hold <= rnd ? 1'($urandom) : stop;
		fills += int'(fill_req && fill_ack);
		if (!reset && wq_valid && wq_ready) got_q.push_back(wq_out);
		cyc++;
		if (cyc == 4000) begin
			err_count++;
			end_sim();
		end
	end
	function automatic logic [127:0] msk(input logic [15:0] b);
		for (int i = 0; i < 16; i++) msk[8*i+:8] = {8{b[i]}};
	endfunction
	task automatic chk(input logic [127:0] g, input logic [127:0] e);
		num_checks++;
		if (g !== e) begin
			err_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic st(input logic [31:0] sa, input logic [127:0] sd,
		input logic [15:0] b, input logic ac, input logic r);
		@(posedge sys_clk);
		st_req <= '{sa, sd, b, ac};
		st_valid <= 1'b1;
		@(negedge sys_clk);
		chk(st_ready, r);
		while (!st_ready) @(negedge sys_clk);
		@(posedge sys_clk);
		st_valid <= 1'b0;
	endtask
	task automatic drain();
		stop <= 1'b0;
		rnd <= 1'b1;
		repeat (40) @(posedge sys_clk);
		rnd <= 1'b0;
		repeat (12) @(posedge sys_clk);
		chk(got_q.size(), exp_q.size());
		foreach (exp_q[i]) if (i < got_q.size()) begin
			chk(got_q[i].be, exp_q[i].be);
			chk(got_q[i].data & msk(exp_q[i].be), exp_q[i].data);
			chk(got_q[i].addr, exp_q[i].addr);
		end
		exp_q = {};
		got_q = {};
	endtask
	task automatic ld(input logic [31:0] la, input logic h);
		@(posedge sys_clk);
		ld_valid <= 1'b1;
		ld_addr <= la;
		@(negedge sys_clk);
		while (!ld_ready) @(negedge sys_clk);
		@(posedge sys_clk);
		ld_valid <= 1'b0;
		@(negedge sys_clk);
		chk({ld_done_r, ld_hit_r, ld_miss_r}, {1'b1, h, !h});
		if (h) chk(ld_data_r, {4{la[31:4], 4'h0}});
		else chk(ld_data_r, 128'h0);
	endtask
	task automatic end_sim();
		$display("checks %0d errors %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial begin
		void'($urandom(32'h75B66D84));
		repeat (10) @(posedge sys_clk);
		chk({st_ready, wq_valid, ld_ready, fill_busy}, 4'hA);
		reset <= 1'b0;
		stop <= 1'b1;
		for (int i = 0; i < 9; i++) begin
			a = $urandom;
			d = {$urandom, $urandom, $urandom, $urandom};
			exp_q.push_back('{a, d, 16'hFFFF});
			if (i < 8) st(a, d, 16'hFFFF, 1'b0, 1'b1);
			else fork
				st(a, d, 16'hFFFF, 1'b0, 1'b0);
				begin repeat (4) @(posedge sys_clk); stop <= 1'b0; end
			join
		end
		drain();
		stop <= 1'b1;
		a = $urandom & 32'hFFFFFFF0;
		st(a, d, 16'h000F, 1'b1, 1'b1);
		st(a, ~d, 16'h00F0, 1'b1, 1'b1);
		st(a, d, 16'hF000, 1'b1, 1'b1);
		exp_q.push_back('{a, d & msk(16'h000F) | ~d & msk(16'h00F0), 16'h00FF});
		exp_q.push_back('{a, d & msk(16'hF000), 16'hF000});
		drain();
		rnd <= 1'b1;
		a = $urandom & 32'hFFFFFF80;
		for (int r = 0; r < 3; r++) begin
			ld(a + 32'h30, 1'b0);
			repeat (2) @(negedge sys_clk);
			chk(fill_addr_r, a);
			while (fill_busy) @(negedge sys_clk);
			for (int k = 0; k < 8; k++) ld(a + 32'h10 * k, 1'b1);
			chk(fills, r + 1);
			// Second pass drops the line by a store into it, not a flush
			if (r == 1) begin
				st(a + 32'h20, d, 16'hFFFF, 1'b1, 1'b1);
				exp_q.push_back('{a + 32'h20, d, 16'hFFFF});
			end else begin
				@(posedge sys_clk);
				llb_flush <= 1'b1;
				@(posedge sys_clk);
				llb_flush <= 1'b0;
			end
		end
		drain();
		end_sim();
	end
endmodule
